/* design/isa_params.svh */
// Constants for the two-wire slave with address masking and clock stretching.
`ifndef ISA_PARAMS_SVH
`define ISA_PARAMS_SVH

`define ISA_BITS_PER_BYTE 4'd8
`define ISA_LAST_TX_BIT   4'd7
`define ISA_TEN_HI_CODE   5'b11110
`define ISA_MASK_WIDTH    5
`define ISA_BUF_DEPTH     2

`endif

/* design/isa_pkg.sv */
// Types shared by the two-wire slave design.
package isa_pkg;

  typedef enum logic [2:0] {
    stIdle,
    stRecv,
    stAck,
    stXmit,
    stAckIn
  } isa_state_t;

  typedef logic [7:0] isa_byte_t;

endpackage

/* design/isa_fifo2.sv */
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module isa_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("isa_fifo2: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [PW:0]      count_q;
  logic             doPush;
  logic             doPop;

  assign inReady  = (count_q != (PW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_ff @(posedge clk)
  begin
    if (doPush)
      mem[wrPtr_q] <= inData;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else if (flush)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (doPop)
        rdPtr_q <= rdPtr_q + 1'b1;
      case ({doPush, doPop})
        2'b10:   count_q <= count_q + 1'b1;
        2'b01:   count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end

endmodule // isa_fifo2
`default_nettype wire

/* design/isa_slave.sv */
// Two-wire bus slave: address match with masking, receive, transmit, clock stretching.
`timescale 1ns/1ns
`default_nettype none
`include "isa_params.svh"

module isa_slave (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               sclIn,
  input  wire logic               sdaIn,
  output logic                    sclOut,
  output logic                    sclOe,
  output logic                    sdaOut,
  output logic                    sdaOe,
  input  wire logic               portEnableBit,
  input  wire logic               tenBitMode,
  input  wire logic               stretchEnable,
  input  wire logic [4:0]         addrMaskBits,
  input  wire logic               ownAddrWr,
  input  wire isa_pkg::isa_byte_t ownAddrWrData,
  input  wire logic               holdingBufRead,
  input  wire logic               holdingBufWr,
  input  wire isa_pkg::isa_byte_t holdingBufWrData,
  input  wire logic               sclReleaseSet,
  input  wire logic               irqFlagClr,
  input  wire logic               overflowClr,
  output isa_pkg::isa_byte_t      holdingBuffer,
  output isa_pkg::isa_byte_t      ownAddressReg,
  output logic                    bufferFullFlag,
  output logic                    receiveOverflowFlag,
  output logic                    portIrqFlag,
  output logic                    updateAddressFlag,
  output logic                    readWriteStat,
  output logic                    sclReleaseBit
);
  import isa_pkg::*;

  // ----------------------------------------------------------------
  // Address compare
  // ----------------------------------------------------------------
  // In low-byte mode mask bit 0 covers two address bits; in seven-bit
  // mode bit 0 carries the direction and is never compared.
  function automatic logic addrMatch(input isa_byte_t rcv, input isa_byte_t own,
                                     input logic [4:0] m, input logic lowByte);
    isa_byte_t care;
    care = lowByte ? ~{2'b00, m[4:1], m[0], m[0]} : ~{2'b00, m, 1'b1};
    return ((rcv ^ own) & care) == 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic sclS1_q;
  logic sclS2_q;
  logic sclS3_q;
  logic sdaS1_q;
  logic sdaS2_q;
  logic sdaS3_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclS1_q <= 1'b1;
      sclS2_q <= 1'b1;
      sclS3_q <= 1'b1;
      sdaS1_q <= 1'b1;
      sdaS2_q <= 1'b1;
      sdaS3_q <= 1'b1;
    end
    else
    begin
      sclS1_q <= sclIn;
      sclS2_q <= sclS1_q;
      sclS3_q <= sclS2_q;
      sdaS1_q <= sdaIn;
      sdaS2_q <= sdaS1_q;
      sdaS3_q <= sdaS2_q;
    end
  end

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  assign sclRise   = sclS2_q && !sclS3_q;
  assign sclFall   = !sclS2_q && sclS3_q;
  assign startSeen = sclS2_q && sclS3_q && !sdaS2_q && sdaS3_q;
  assign stopSeen  = sclS2_q && sclS3_q && sdaS2_q && !sdaS3_q;

  // ----------------------------------------------------------------
  // State and decision signals
  // ----------------------------------------------------------------
  isa_state_t state_q;
  logic [3:0] bitCnt_q;
  isa_byte_t  shift_q;
  isa_byte_t  ownAddr_q;
  logic       addrByte_q;
  logic       phaseLow_q;
  logic       tenDone_q;
  logic       ackDrive_q;
  logic       goTx_q;
  logic       uaStep_q;
  logic       masterNack_q;
  logic       txFull_q;
  logic       ua_q;
  logic       ov_q;
  logic       irq_q;
  logic       ckp_q;
  logic       uaHold_q;
  logic       rxInReady;
  logic       rxValid;
  isa_byte_t  rxData;
  logic       busyBuf;
  logic       byteDone;
  logic       ninthFall;
  logic       matched;
  logic       ackIt;
  logic       isRead;
  logic       pushRx;
  logic       setOv;

  assign busyBuf   = rxValid || txFull_q;
  assign byteDone  = (state_q == stRecv) && sclFall && (bitCnt_q == `ISA_BITS_PER_BYTE);
  assign ninthFall = sclFall && ((state_q == stAck) || (state_q == stAckIn));

  always_comb
  begin
    matched = 1'b0;
    isRead  = 1'b0;
    ackIt   = 1'b0;
    pushRx  = 1'b0;
    setOv   = 1'b0;
    if (byteDone)
    begin
      if (addrByte_q)
      begin
        if (!tenBitMode)
        begin
          matched = addrMatch(shift_q, ownAddr_q, addrMaskBits, 1'b0);
          isRead  = shift_q[0];
        end
        else if (phaseLow_q)
          matched = addrMatch(shift_q, ownAddr_q, addrMaskBits, 1'b1);
        else
        begin
          // High byte is never masked; a read needs a completed address.
          matched = (shift_q[7:3] == `ISA_TEN_HI_CODE) &&
                    (shift_q[2:1] == ownAddr_q[2:1]) &&
                    (!shift_q[0] || tenDone_q);
          isRead  = shift_q[0];
        end
        ackIt  = matched && !busyBuf && !ov_q;
        pushRx = ackIt;
      end
      else
      begin
        ackIt  = !busyBuf && !ov_q && rxInReady;
        pushRx = ackIt;
        setOv  = !ackIt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q      <= stIdle;
      bitCnt_q     <= '0;
      shift_q      <= '0;
      addrByte_q   <= 1'b0;
      phaseLow_q   <= 1'b0;
      tenDone_q    <= 1'b0;
      ackDrive_q   <= 1'b0;
      goTx_q       <= 1'b0;
      uaStep_q     <= 1'b0;
      masterNack_q <= 1'b0;
    end
    else if (!portEnableBit)
    begin
      state_q    <= stIdle;
      bitCnt_q   <= '0;
      addrByte_q <= 1'b0;
      phaseLow_q <= 1'b0;
      tenDone_q  <= 1'b0;
      ackDrive_q <= 1'b0;
      goTx_q     <= 1'b0;
    end
    else if (startSeen)
    begin
      state_q    <= stRecv;
      bitCnt_q   <= '0;
      addrByte_q <= 1'b1;
      phaseLow_q <= 1'b0;
      ackDrive_q <= 1'b0;
    end
    else if (stopSeen)
    begin
      state_q    <= stIdle;
      tenDone_q  <= 1'b0;
      phaseLow_q <= 1'b0;
      ackDrive_q <= 1'b0;
    end
    else
    begin
      if (holdingBufWr)
        shift_q <= holdingBufWrData;
      case (state_q)
        stRecv:
        begin
          if (sclRise && bitCnt_q != `ISA_BITS_PER_BYTE)
          begin
            shift_q  <= {shift_q[6:0], sdaS2_q};
            bitCnt_q <= bitCnt_q + 1'b1;
          end
          else if (byteDone)
          begin
            if (addrByte_q && !ackIt)
              state_q <= stIdle;
            else
              state_q <= stAck;
            ackDrive_q <= ackIt;
            goTx_q     <= addrByte_q && isRead;
            uaStep_q   <= addrByte_q && tenBitMode && !isRead;
          end
        end
        stAck:
        begin
          if (sclFall)
          begin
            ackDrive_q <= 1'b0;
            bitCnt_q   <= '0;
            if (goTx_q)
            begin
              state_q    <= stXmit;
              addrByte_q <= 1'b0;
            end
            else
            begin
              state_q <= stRecv;
              if (uaStep_q && !phaseLow_q)
                phaseLow_q <= 1'b1;
              else
              begin
                addrByte_q <= 1'b0;
                phaseLow_q <= 1'b0;
                if (uaStep_q)
                  tenDone_q <= 1'b1;
              end
            end
          end
        end
        stXmit:
        begin
          if (sclFall)
          begin
            shift_q  <= {shift_q[6:0], 1'b0};
            bitCnt_q <= bitCnt_q + 1'b1;
            if (bitCnt_q == `ISA_LAST_TX_BIT)
              state_q <= stAckIn;
          end
        end
        stAckIn:
        begin
          if (sclRise)
            masterNack_q <= sdaS2_q;
          else if (sclFall)
          begin
            bitCnt_q <= '0;
            if (masterNack_q)
            begin
              state_q   <= stIdle;
              tenDone_q <= 1'b0;
            end
            else
              state_q <= stXmit;
          end
        end
        default:
          state_q <= stIdle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  // A full buffer also stalls SCL; without stretchEnable a data byte that arrives before the last one is read is refused and sets the overflow flag.
  isa_fifo2 #(
    .WIDTH (8),
    .DEPTH (`ISA_BUF_DEPTH)
  ) u_rxBuf (
    .clk      (clk),
    .rst_b    (rst_b),
    .flush    (!portEnableBit),
    .inValid  (pushRx),
    .inReady  (rxInReady),
    .inData   (shift_q),
    .outValid (rxValid),
    .outReady (holdingBufRead),
    .outData  (rxData)
  );

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Hardware sets win over software clears in the same cycle.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      txFull_q  <= 1'b0;
      ua_q      <= 1'b0;
      ov_q      <= 1'b0;
      irq_q     <= 1'b0;
      ownAddr_q <= '0;
      readWriteStat <= 1'b0;
    end
    else
    begin
      if (ownAddrWr)
        ownAddr_q <= ownAddrWrData;
      if (holdingBufWr)
        txFull_q <= 1'b1;
      else if (state_q == stXmit && sclFall && bitCnt_q == `ISA_LAST_TX_BIT)
        txFull_q <= 1'b0;
      if (byteDone && ackIt && addrByte_q && tenBitMode && !isRead)
        ua_q <= 1'b1;
      else if (ownAddrWr || !portEnableBit)
        ua_q <= 1'b0;
      if (setOv)
        ov_q <= 1'b1;
      else if (overflowClr)
        ov_q <= 1'b0;
      if (ninthFall)
        irq_q <= 1'b1;
      else if (irqFlagClr)
        irq_q <= 1'b0;
      if (byteDone && ackIt && addrByte_q)
        readWriteStat <= isRead;
    end
  end

  // ----------------------------------------------------------------
  // Clock stretching
  // ----------------------------------------------------------------
  logic rxStretch;
  logic txStretch;
  logic holdWant;

  assign rxStretch = (state_q == stAck) && !goTx_q && !addrByte_q &&
                     stretchEnable && busyBuf;
  assign txStretch = ((state_q == stAck) && goTx_q) ||
                     ((state_q == stAckIn) && !masterNack_q);
  assign holdWant  = (state_q != stIdle) &&
                     (!ckp_q || uaHold_q || !rxInReady);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ckp_q    <= 1'b1;
      uaHold_q <= 1'b0;
      sclOe    <= 1'b0;
    end
    else
    begin
      // The auto clear is the bus event and wins over a software release.
      if (sclFall && (rxStretch || (txStretch && !txFull_q)))
        ckp_q <= 1'b0;
      else if (sclReleaseSet)
        ckp_q <= 1'b1;
      if (sclFall && (state_q == stAck) && uaStep_q && ua_q)
        uaHold_q <= 1'b1;
      else if (ownAddrWr || !portEnableBit)
        uaHold_q <= 1'b0;
      // Only pull SCL once it is already seen low, so the high time is kept.
      sclOe <= portEnableBit && holdWant && (sclOe || !sclS2_q);
    end
  end

  // ----------------------------------------------------------------
  // Data line and registered status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sdaOe               <= 1'b0;
      sclOut              <= 1'b0;
      sdaOut              <= 1'b0;
      holdingBuffer       <= '0;
      ownAddressReg       <= '0;
      bufferFullFlag      <= 1'b0;
      receiveOverflowFlag <= 1'b0;
      portIrqFlag         <= 1'b0;
      updateAddressFlag   <= 1'b0;
      sclReleaseBit       <= 1'b1;
    end
    else
    begin
      sdaOe <= portEnableBit &&
               (((state_q == stAck) && ackDrive_q) ||
                ((state_q == stXmit) && !shift_q[7]));
      sclOut              <= 1'b0;
      sdaOut              <= 1'b0;
      holdingBuffer       <= rxData;
      ownAddressReg       <= ownAddr_q;
      bufferFullFlag      <= busyBuf;
      receiveOverflowFlag <= ov_q;
      portIrqFlag         <= irq_q;
      updateAddressFlag   <= ua_q;
      sclReleaseBit       <= ckp_q;
    end
  end

endmodule // isa_slave
`default_nettype wire

/* tb/isa_slave_monitor.sv */
// Concurrent port checks for the two-wire slave.
`timescale 1ns/1ns
`default_nettype none
module isa_slave_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic portEnableBit,
  input wire logic ownAddrWr,
  input wire logic holdingBufRead,
  input wire logic sclReleaseSet,
  input wire logic irqFlagClr,
  input wire logic bufferFullFlag,
  input wire logic portIrqFlag,
  input wire logic updateAddressFlag,
  input wire logic readWriteStat,
  input wire logic sclReleaseBit
);
  default clocking mcb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Status outputs trail their software cause by two edges.
  port_off_a: assert property (!portEnableBit [*3] |-> !sclOe && !sdaOe)
    else $error("bus pulled while port disabled");
  open_drain_a: assert property (!sclOut && !sdaOut)
    else $error("open drain data not low");
  pull_late_a: assert property ($rose(sclOe) |-> !$past(sclIn))
    else $error("clock pulled before it was seen low");
  auto_clear_a: assert property ($fell(sclReleaseBit)
    |-> (bufferFullFlag || readWriteStat) && !updateAddressFlag)
    else $error("release bit cleared without cause");
  release_set_a: assert property (sclReleaseSet |-> ##2 sclReleaseBit)
    else $error("release bit not set");
  irq_sticky_a: assert property ($fell(portIrqFlag) |-> $past(irqFlagClr, 2))
    else $error("irq flag dropped by itself");
  full_clear_a: assert property ($fell(bufferFullFlag) && !readWriteStat
    |-> $past(holdingBufRead, 2) || !$past(portEnableBit, 2))
    else $error("full flag dropped without read");
  ua_clear_a: assert property ($fell(updateAddressFlag)
    |-> $past(ownAddrWr, 2) || !$past(portEnableBit, 2))
    else $error("update flag dropped without write");
endmodule // isa_slave_monitor
`default_nettype wire

/* tb/isa_bus_master.sv */
// Behavioural two-wire bus master that clocks the slave from the far side.
`timescale 1ns/1ns
`default_nettype none
module isa_bus_master (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output var logic  sclDrv,
  output var logic  sdaDrv,
  output var logic  hung
);
  int halfCycles = 8;
  initial
  begin
    sclDrv = 1'b0;
    sdaDrv = 1'b0;
    hung = 1'b0;
  end
  // The slave may stretch the low phase; a bound stops a hang and flags it.
  task automatic waitHigh();
    int n;
    n = 0;
    sclDrv <= 1'b0;
    @(posedge clk);
    while (!scl && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) hung = 1'b1;
  endtask
  // Data moves two cycles into the low phase so that no edge reads as Start or Stop.
  task automatic bitIo(input logic b, output logic s);
    sclDrv <= 1'b1;
    repeat (2) @(posedge clk);
    sdaDrv <= !b;
    repeat (halfCycles - 2) @(posedge clk);
    waitHigh();
    repeat (halfCycles / 2) @(posedge clk);
    s = sda;
    // The wait for a high clock costs one cycle, so the high phase gives it back.
    repeat (halfCycles / 2 - 1) @(posedge clk);
  endtask
  task automatic frameEdge(input logic start);
    sclDrv <= 1'b1;
    repeat (2) @(posedge clk);
    sdaDrv <= !start;
    repeat (halfCycles) @(posedge clk);
    waitHigh();
    repeat (halfCycles) @(posedge clk);
    sdaDrv <= start;
    repeat (halfCycles) @(posedge clk);
  endtask
  task automatic sendByte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(v[i], s);
    bitIo(1'b1, s);
    ack = !s;
  endtask
  task automatic recvByte(input logic ackIt, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitIo(1'b1, s);
      v[i] = s;
    end
    bitIo(!ackIt, s);
  endtask
endmodule // isa_bus_master
`default_nettype wire

/* tb/isa_slave_test.sv */
// Self-checking bench for the two-wire slave.
`timescale 1ns/1ns
`default_nettype none
module isa_slave_test;
  import isa_pkg::*;
  logic        clk, rst_b, portEnableBit, tenBitMode, stretchEnable, sclOe, sdaOe;
  logic        bufferFullFlag, receiveOverflowFlag, portIrqFlag, updateAddressFlag;
  logic        readWriteStat, sclReleaseBit, sclDrv, sdaDrv, hung, bfPrev;
  logic [4:0]  addrMaskBits;
  logic [5:0]  swReq;
  logic [31:0] seed;
  isa_byte_t   ownAddrWrData, holdingBufWrData, holdingBuffer, ownAddressReg;
  isa_byte_t   expQ[$], txQ[$], uaQ[$];
  int          n_errors, num_checks;
  wire logic   sclLine = !(sclDrv || sclOe);
  wire logic   sdaLine = !(sdaDrv || sdaOe);
  isa_slave isa_slave_i (
    .clk, .rst_b, .sclIn(sclLine), .sdaIn(sdaLine), .sclOut(), .sclOe, .sdaOut(), .sdaOe,
    .portEnableBit, .tenBitMode, .stretchEnable, .addrMaskBits, .ownAddrWr(swReq[0]),
    .ownAddrWrData, .holdingBufRead(swReq[1]), .holdingBufWr(swReq[2]), .holdingBufWrData,
    .sclReleaseSet(swReq[3]), .irqFlagClr(swReq[4]), .overflowClr(swReq[5]), .holdingBuffer,
    .ownAddressReg, .bufferFullFlag, .receiveOverflowFlag, .portIrqFlag, .updateAddressFlag,
    .readWriteStat, .sclReleaseBit
  );
  isa_bus_master isa_bus_master_i (.clk, .scl(sclLine), .sda(sdaLine), .sclDrv, .sdaDrv, .hung);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic isa_byte_t rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chkBit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic chkByte(input string what, input isa_byte_t exp, input isa_byte_t got);
    num_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic pulse(input int i);
    swReq <= 6'h01 << i;
    @(posedge clk);
    swReq <= 6'h00;
    repeat (2) @(posedge clk);
  endtask
  // --------------------------------------------------------------
  // Software side: a service routine run once per raised irq flag.
  // --------------------------------------------------------------
  task automatic isr(input int n, input logic [7:0] hold);
    int t;
    for (int k = 0; k < n; k++)
    begin
      t = 0;
      while (portIrqFlag !== 1'b1 && t < 4000)
      begin
        @(posedge clk);
        t++;
      end
      if (t >= 4000)
      begin
        n_errors++;
        final_report();
      end
      repeat (14) @(posedge clk);
      chkBit("sclHeld", hold[k], sclOe);
      if (updateAddressFlag === 1'b1 && uaQ.size() > 0)
      begin
        ownAddrWrData <= uaQ.pop_front();
        pulse(0);
      end
      if (bufferFullFlag === 1'b1) pulse(1);
      if (readWriteStat === 1'b1 && txQ.size() > 0)
      begin
        holdingBufWrData <= txQ.pop_front();
        pulse(2);
      end
      pulse(4);
      pulse(3);
    end
  endtask
  task automatic addrOnly(input isa_byte_t a, input logic exp);
    logic ack;
    isa_bus_master_i.frameEdge(1'b1);
    isa_bus_master_i.sendByte(a, ack);
    chkBit("addrAck", exp, ack);
    isa_bus_master_i.frameEdge(1'b0);
  endtask
  task automatic wrXfer(input logic [7:0] hold);
    isa_byte_t d[2];
    logic      ack;
    expQ.push_back(8'ha0);
    for (int i = 0; i < 2; i++)
    begin
      d[i] = rnd8();
      expQ.push_back(d[i]);
    end
    fork
      begin
        isa_bus_master_i.frameEdge(1'b1);
        isa_bus_master_i.sendByte(8'ha0, ack);
        chkBit("addrAck", 1'b1, ack);
        for (int i = 0; i < 2; i++)
        begin
          isa_bus_master_i.sendByte(d[i], ack);
          chkBit("dataAck", 1'b1, ack);
        end
        isa_bus_master_i.frameEdge(1'b0);
      end
      isr(3, hold);
    join
  endtask
  // Holding buffer contents are compared when the full flag rises on receive.
  always @(posedge clk)
  begin
    bfPrev <= bufferFullFlag;
    if (rst_b && bufferFullFlag === 1'b1 && bfPrev === 1'b0 && readWriteStat === 1'b0)
    begin
      if (expQ.size() > 0) chkByte("holdingBuffer", expQ.pop_front(), holdingBuffer);
      else chkByte("holdingBuffer", ~holdingBuffer, holdingBuffer);
    end
  end
  // A master stuck on a held clock ends the run at once.
  always @(posedge clk)
  begin
    if (hung === 1'b1)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    logic      ack, hit;
    isa_byte_t a, r, b, t0, t1;
    seed = 32'd82470;
    {rst_b, portEnableBit, tenBitMode, stretchEnable, bfPrev} = 5'b00000;
    addrMaskBits = 5'h00;
    swReq = 6'h00;
    ownAddrWrData = 8'h00;
    holdingBufWrData = 8'h00;
    n_errors = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    portEnableBit <= 1'b1;
    repeat (4) @(posedge clk);
    chkBit("releaseBit", 1'b1, sclReleaseBit);
    ownAddrWrData <= 8'ha0;
    pulse(0);
    chkByte("ownAddressReg", 8'ha0, ownAddressReg);
    wrXfer(8'h00);
    stretchEnable <= 1'b1;
    wrXfer(8'h06);
    t0 = rnd8();
    t1 = rnd8();
    txQ = '{t0, t1};
    fork
      begin
        isa_bus_master_i.frameEdge(1'b1);
        isa_bus_master_i.sendByte(8'ha1, ack);
        chkBit("readAddrAck", 1'b1, ack);
        chkBit("readWrite", 1'b1, readWriteStat);
        isa_bus_master_i.recvByte(1'b1, b);
        chkByte("txByte", t0, b);
        isa_bus_master_i.recvByte(1'b0, b);
        chkByte("txByte", t1, b);
        isa_bus_master_i.frameEdge(1'b0);
      end
      isr(3, 8'h03);
    join
    stretchEnable <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      r = rnd8();
      a = rnd8();
      addrMaskBits <= r[4:0];
      a = (r[7] ? (8'ha0 ^ (a & {2'b00, r[4:0], 1'b0})) : a) & 8'hfe;
      hit = ((a ^ 8'ha0) & ~{2'b00, r[4:0], 1'b0} & 8'hfe) == 8'h00;
      if (hit) expQ.push_back(a);
      @(posedge clk);
      fork
        addrOnly(a, hit);
        isr(hit ? 1 : 0, 8'h00);
      join
    end
    addrMaskBits <= 5'h00;
    expQ.push_back(8'ha0);
    isa_bus_master_i.frameEdge(1'b1);
    isa_bus_master_i.sendByte(8'ha0, ack);
    chkBit("addrAck", 1'b1, ack);
    isa_bus_master_i.sendByte(rnd8(), ack);
    chkBit("fullDataAck", 1'b0, ack);
    isa_bus_master_i.frameEdge(1'b0);
    chkBit("overflow", 1'b1, receiveOverflowFlag);
    chkBit("irqFlag", 1'b1, portIrqFlag);
    addrOnly(8'ha0, 1'b0);
    pulse(1);
    pulse(4);
    pulse(5);
    chkBit("bufferFull", 1'b0, bufferFullFlag);
    chkBit("irqFlag", 1'b0, portIrqFlag);
    chkBit("overflow", 1'b0, receiveOverflowFlag);
    portEnableBit <= 1'b0;
    addrOnly(8'ha0, 1'b0);
    portEnableBit <= 1'b1;
    tenBitMode <= 1'b1;
    ownAddrWrData <= 8'hf2;
    pulse(0);
    a = rnd8();
    t0 = rnd8();
    expQ = '{8'hf2, 8'h34, a};
    uaQ = '{8'h34, 8'hf2};
    txQ = '{t0};
    fork
      begin
        isa_bus_master_i.frameEdge(1'b1);
        isa_bus_master_i.sendByte(8'hf2, ack);
        chkBit("highAddrAck", 1'b1, ack);
        chkBit("updateAddr", 1'b1, updateAddressFlag);
        isa_bus_master_i.sendByte(8'h34, ack);
        chkBit("lowAddrAck", 1'b1, ack);
        isa_bus_master_i.sendByte(a, ack);
        chkBit("dataAck", 1'b1, ack);
        isa_bus_master_i.frameEdge(1'b1);
        isa_bus_master_i.sendByte(8'hf3, ack);
        chkBit("readAddrAck", 1'b1, ack);
        chkBit("updateAddr", 1'b0, updateAddressFlag);
        chkBit("readWrite", 1'b1, readWriteStat);
        isa_bus_master_i.recvByte(1'b0, b);
        chkByte("txByte", t0, b);
        isa_bus_master_i.frameEdge(1'b0);
      end
      isr(5, 8'h0b);
    join
    repeat (20) @(posedge clk);
    chkBit("masterStall", 1'b0, hung);
    chkBit("allBytesSeen", 1'b1, expQ.size() == 0);
    final_report();
  end
endmodule // isa_slave_test
bind isa_slave isa_slave_monitor isa_slave_monitor_i (
  .clk, .rst_b, .sclIn, .sclOut, .sclOe, .sdaOut, .sdaOe, .portEnableBit, .ownAddrWr,
  .holdingBufRead, .sclReleaseSet, .irqFlagClr, .bufferFullFlag, .portIrqFlag,
  .updateAddressFlag, .readWriteStat, .sclReleaseBit
);
`default_nettype wire
